// ==== dacc_core.sv ====
// module: per-channel address, count and control registers on ahb-lite
//
// Behaviour
// - source address register, 32-bit, shows next address
// - source write also updates its shadow
// - wrap reloads source from shadow unless renewal is destination-only, channels 0-3
// - destination address register, shows next address
// - destination write also updates shadow; shadow restored on wrap unless renewal is source-only
// - count 24 bits, zero means maximum
// - count register shows transfers remaining
// - count upper eight bits read zero
// - count write also stores count shadow
// - repeat mode reloads count from shadow
// - reload mode: shadow low half counts, refills
// - control bit 30 releases bus between
// - renewal field selects normal, repeat, reload
// - renewal only channels 0-3, 100 reserved
// - control bit 23 overrun select, channels 0-1
// - four-bit size code selects unit size
// - divided sizes move two half units
// - reserved control bits read zero
// - done flag sets as count reaches zero
// - increment mode advances by unit size
`default_nettype none
module dacc_core
  import dacc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic step_valid,
  input wire logic [2:0] step_chan,
  input wire logic step_second,
  output dacc_cfg_t chan_cfg [CHANNELS]
);

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  function automatic dacc_dec_t decode(input logic [31:0] a);
    dacc_dec_t d;
    d.hit = 1'b0;
    d.chan = 3'h0;
    d.kind = DACC_REG_NONE;
    for (int c = 0; c < CHANNELS; c++) begin
      if (a[11:4] == CH_BASE[c][11:4] && a[1:0] == 2'h0) begin
        d.hit = 1'b1;
        d.chan = 3'(c);
        case (a[3:0])
          OFS_SRC: d.kind = DACC_REG_SRC;
          OFS_DST: d.kind = DACC_REG_DST;
          OFS_CNT: d.kind = DACC_REG_CNT;
          default: d.kind = DACC_REG_CTRL;
        endcase
      end
    end
    for (int c = 0; c < RENEW_CHANNELS; c++) begin
      if (a[11:4] == 8'((SHADOW_BASE + 12'(c) * SHADOW_STRIDE) >> 4)
          && a[1:0] == 2'h0 && a[3:0] != OFS_CTRL) begin
        d.hit = 1'b1;
        d.chan = 3'(c);
        case (a[3:0])
          OFS_SRC: d.kind = DACC_REG_SRCB;
          OFS_DST: d.kind = DACC_REG_DSTB;
          default: d.kind = DACC_REG_CNTB;
        endcase
      end
    end
    if (a[31:12] != 20'h0_0000) begin
      d.hit = 1'b0;
      d.kind = DACC_REG_NONE;
    end
    return d;
  endfunction : decode

  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  logic [31:0] src_addr_reg [CHANNELS];
  logic [31:0] dst_addr_reg [CHANNELS];
  logic [31:0] xfer_count_reg [CHANNELS];
  logic [31:0] channel_ctrl_reg [CHANNELS];
  logic [31:0] src_addr_shadow [RENEW_CHANNELS];
  logic [31:0] dst_addr_shadow [RENEW_CHANNELS];
  logic [31:0] xfer_count_shadow [RENEW_CHANNELS];

  // ------------------------------------------------------------
  // bus slave: address and data phase
  // ------------------------------------------------------------
  logic [31:0] ph_addr;
  logic wr_pend;
  logic rd_pend;
  logic accept;
  dacc_dec_t wr_dec;
  dacc_dec_t rd_dec;

  assign accept = hsel && hready && htrans[1];
  assign wr_dec = decode(ph_addr);
  assign rd_dec = decode(ph_addr);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_addr <= REG_RESET;
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
    end else begin
      if (accept) begin
        ph_addr <= haddr;
      end
      wr_pend <= accept && hwrite;
      rd_pend <= accept && !hwrite;
    end
  end

  // reads take one wait state because hrdata is registered from the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= !(accept && !hwrite);
      hresp <= 1'b0;
    end
  end

  logic [31:0] rd_value;

  always_comb begin
    rd_value = 32'h0000_0000;
    if (rd_dec.hit) begin
      case (rd_dec.kind)
        DACC_REG_SRC: rd_value = src_addr_reg[rd_dec.chan];
        DACC_REG_DST: rd_value = dst_addr_reg[rd_dec.chan];
        DACC_REG_CNT: rd_value = xfer_count_reg[rd_dec.chan] & CNT_MASK;
        DACC_REG_CTRL: rd_value = channel_ctrl_reg[rd_dec.chan];
        DACC_REG_SRCB: rd_value = src_addr_shadow[rd_dec.chan[1:0]];
        DACC_REG_DSTB: rd_value = dst_addr_shadow[rd_dec.chan[1:0]];
        DACC_REG_CNTB: rd_value = xfer_count_shadow[rd_dec.chan[1:0]];
        default: rd_value = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= REG_RESET;
    end else if (rd_pend) begin
      hrdata <= rd_value;
    end
  end

  // ------------------------------------------------------------
  // per-channel datapath
  // ------------------------------------------------------------
  for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
    logic [3:0] size_code;
    logic [2:0] renew;
    logic repeat_mode;
    logic reload_mode;
    logic step_hit;
    logic unit_end;
    logic [23:0] next_cnt;
    logic wrap;
    logic reload_src;
    logic reload_dst;
    logic [31:0] src_next;
    logic [31:0] dst_next;
    logic src_ok;
    logic dst_ok;
    logic divided;
    logic w_src;
    logic w_dst;
    logic w_cnt;
    logic w_ctrl;

    assign size_code = {channel_ctrl_reg[i][BIT_SIZE_HI_HI:BIT_SIZE_HI_LO],
      channel_ctrl_reg[i][BIT_SIZE_LO_HI:BIT_SIZE_LO_LO]};
    // renewal has effect only on the lower channels
    assign renew = (i < RENEW_CHANNELS) ?
      channel_ctrl_reg[i][BIT_RENEW_HI:BIT_RENEW_LO] : RENEW_NORMAL;
    assign repeat_mode = !renew[2] && renew[1:0] != 2'h0;
    assign reload_mode = renew[2] && renew[1:0] != 2'h0;
    assign step_hit = step_valid && step_chan == 3'(i)
      && channel_ctrl_reg[i][BIT_ENABLE] && !channel_ctrl_reg[i][BIT_DONE];
    assign unit_end = step_hit && (!divided || step_second);
    assign next_cnt = xfer_count_reg[i][23:0] - 24'h00_0001;

    assign w_src = wr_pend && wr_dec.hit && wr_dec.chan == 3'(i)
      && wr_dec.kind == DACC_REG_SRC;
    assign w_dst = wr_pend && wr_dec.hit && wr_dec.chan == 3'(i)
      && wr_dec.kind == DACC_REG_DST;
    assign w_cnt = wr_pend && wr_dec.hit && wr_dec.chan == 3'(i)
      && wr_dec.kind == DACC_REG_CNT;
    assign w_ctrl = wr_pend && wr_dec.hit && wr_dec.chan == 3'(i)
      && wr_dec.kind == DACC_REG_CTRL;

    dacc_step u_src_step (
      .addr(src_addr_reg[i]),
      .mode(channel_ctrl_reg[i][BIT_SRC_MODE_HI:BIT_SRC_MODE_LO]),
      .size_code(size_code),
      .second_part(step_second),
      .next_addr(src_next),
      .size_ok(src_ok),
      .divided(divided)
    );

    dacc_step u_dst_step (
      .addr(dst_addr_reg[i]),
      .mode(channel_ctrl_reg[i][BIT_DST_MODE_HI:BIT_DST_MODE_LO]),
      .size_code(size_code),
      .second_part(step_second),
      .next_addr(dst_next),
      .size_ok(dst_ok),
      .divided()
    );

    if (i < RENEW_CHANNELS) begin : g_shadow
      logic w_srcb;
      logic w_dstb;
      logic w_cntb;
      logic [15:0] next_low;

      assign w_srcb = wr_pend && wr_dec.hit && wr_dec.chan == 3'(i)
        && wr_dec.kind == DACC_REG_SRCB;
      assign w_dstb = wr_pend && wr_dec.hit && wr_dec.chan == 3'(i)
        && wr_dec.kind == DACC_REG_DSTB;
      assign w_cntb = wr_pend && wr_dec.hit && wr_dec.chan == 3'(i)
        && wr_dec.kind == DACC_REG_CNTB;
      assign next_low = xfer_count_shadow[i][15:0] - 16'h0001;
      assign wrap = unit_end && ((repeat_mode && next_cnt == 24'h00_0000)
        || (reload_mode && next_low == 16'h0000));
      assign reload_src = wrap && renew[1:0] != RENEW_D;
      assign reload_dst = wrap && renew[1:0] != RENEW_S;

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          src_addr_shadow[i] <= REG_RESET;
        end else if (w_src || w_srcb) begin
          src_addr_shadow[i] <= hwdata;
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          dst_addr_shadow[i] <= REG_RESET;
        end else if (w_dst || w_dstb) begin
          dst_addr_shadow[i] <= hwdata;
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          xfer_count_shadow[i] <= REG_RESET;
        end else if (w_cnt || w_cntb) begin
          xfer_count_shadow[i] <= hwdata;
        end else if (unit_end && reload_mode) begin
          if (next_low == 16'h0000) begin
            xfer_count_shadow[i][15:0] <= xfer_count_shadow[i][31:16];
          end else begin
            xfer_count_shadow[i][15:0] <= next_low;
          end
        end
      end
    end else begin : g_plain
      assign wrap = 1'b0;
      assign reload_src = 1'b0;
      assign reload_dst = 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        src_addr_reg[i] <= REG_RESET;
      end else if (w_src) begin
        src_addr_reg[i] <= hwdata;
      end else if (reload_src) begin
        src_addr_reg[i] <= src_addr_shadow[i % RENEW_CHANNELS];
      end else if (step_hit) begin
        src_addr_reg[i] <= src_next;
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        dst_addr_reg[i] <= REG_RESET;
      end else if (w_dst) begin
        dst_addr_reg[i] <= hwdata;
      end else if (reload_dst) begin
        dst_addr_reg[i] <= dst_addr_shadow[i % RENEW_CHANNELS];
      end else if (step_hit) begin
        dst_addr_reg[i] <= dst_next;
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        xfer_count_reg[i] <= REG_RESET;
      end else if (w_cnt) begin
        xfer_count_reg[i] <= hwdata & CNT_MASK;
      end else if (wrap && repeat_mode) begin
        xfer_count_reg[i] <=
          xfer_count_shadow[i % RENEW_CHANNELS] & CNT_MASK;
      end else if (unit_end) begin
        xfer_count_reg[i] <= {8'h00, next_cnt};
      end
    end

    // control fields; done flag set wins over a clearing write
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        channel_ctrl_reg[i] <= REG_RESET;
      end else begin
        if (w_ctrl) begin
          // done bit is cleared by writing zero, kept by writing one
          channel_ctrl_reg[i] <= hwdata & CTRL_WR_MASK;
          if (hwdata[BIT_DONE]) begin
            channel_ctrl_reg[i][BIT_DONE] <= channel_ctrl_reg[i][BIT_DONE];
          end
        end
        if (unit_end && next_cnt == 24'h00_0000 && !repeat_mode) begin
          channel_ctrl_reg[i][BIT_DONE] <= 1'b1;
        end
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        chan_cfg[i] <= '0;
      end else begin
        chan_cfg[i].enable <= channel_ctrl_reg[i][BIT_ENABLE];
        chan_cfg[i].bus_release_between_rw <=
          channel_ctrl_reg[i][BIT_RELEASE];
        chan_cfg[i].overrun_sel <= (i < OVERRUN_CHANNELS) &&
          channel_ctrl_reg[i][BIT_OVERRUN];
        chan_cfg[i].unit_size <= size_code;
        chan_cfg[i].size_ok <= src_ok && dst_ok;
        chan_cfg[i].transfer_done_flag <= channel_ctrl_reg[i][BIT_DONE];
      end
    end
  end

endmodule : dacc_core
`default_nettype wire

// ==== dacc_pkg.sv ====
// package: register map, field layout and types of the dma channel core
`default_nettype none
package dacc_pkg;

  // ------------------------------------------------------------
  // channel counts
  // ------------------------------------------------------------
  localparam int CHANNELS = 6;
  localparam int RENEW_CHANNELS = 4;
  localparam int OVERRUN_CHANNELS = 2;

  // ------------------------------------------------------------
  // register map (byte addresses, low 12 bits)
  // ------------------------------------------------------------
  localparam logic [11:0] CH_BASE [CHANNELS] = '{
    12'h020, 12'h030, 12'h040, 12'h050, 12'h070, 12'h080
  };
  localparam logic [11:0] SHADOW_BASE = 12'h120;
  localparam logic [11:0] SHADOW_STRIDE = 12'h010;
  localparam logic [3:0] OFS_SRC = 4'h0;
  localparam logic [3:0] OFS_DST = 4'h4;
  localparam logic [3:0] OFS_CNT = 4'h8;
  localparam logic [3:0] OFS_CTRL = 4'hC;

  // ------------------------------------------------------------
  // reset values and masks
  // ------------------------------------------------------------
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [31:0] CNT_MASK = 32'h00FF_FFFF;
  localparam logic [31:0] CTRL_WR_MASK = 32'h4EB7_FFFD;

  // ------------------------------------------------------------
  // channel control fields
  // ------------------------------------------------------------
  localparam int BIT_RELEASE = 30;
  localparam int BIT_RENEW_HI = 27;
  localparam int BIT_RENEW_LO = 25;
  localparam int BIT_OVERRUN = 23;
  localparam int BIT_SIZE_HI_HI = 21;
  localparam int BIT_SIZE_HI_LO = 20;
  localparam int BIT_DST_MODE_HI = 15;
  localparam int BIT_DST_MODE_LO = 14;
  localparam int BIT_SRC_MODE_HI = 13;
  localparam int BIT_SRC_MODE_LO = 12;
  localparam int BIT_SIZE_LO_HI = 4;
  localparam int BIT_SIZE_LO_LO = 3;
  localparam int BIT_DONE = 1;
  localparam int BIT_ENABLE = 0;

  // ------------------------------------------------------------
  // transfer size codes and address modes
  // ------------------------------------------------------------
  localparam logic [3:0] SZ_BYTE = 4'h0;
  localparam logic [3:0] SZ_WORD = 4'h1;
  localparam logic [3:0] SZ_LONG = 4'h2;
  localparam logic [3:0] SZ_16 = 4'h3;
  localparam logic [3:0] SZ_32 = 4'h4;
  localparam logic [3:0] SZ_8 = 4'h7;
  localparam logic [3:0] SZ_16_DIV = 4'hB;
  localparam logic [3:0] SZ_32_DIV = 4'hC;
  localparam logic [1:0] AM_FIXED = 2'h0;
  localparam logic [1:0] AM_INC = 2'h1;
  localparam logic [1:0] AM_DEC = 2'h2;
  localparam logic [1:0] AM_HOLD = 2'h3;
  localparam logic [2:0] RENEW_NORMAL = 3'h0;
  localparam logic [1:0] RENEW_SD = 2'h1;
  localparam logic [1:0] RENEW_D = 2'h2;
  localparam logic [1:0] RENEW_S = 2'h3;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    DACC_REG_SRC = 3'h0,
    DACC_REG_DST = 3'h1,
    DACC_REG_CNT = 3'h2,
    DACC_REG_CTRL = 3'h3,
    DACC_REG_SRCB = 3'h4,
    DACC_REG_DSTB = 3'h5,
    DACC_REG_CNTB = 3'h6,
    DACC_REG_NONE = 3'h7
  } dacc_reg_t;

  typedef struct packed {
    logic hit;
    logic [2:0] chan;
    dacc_reg_t kind;
  } dacc_dec_t;

  typedef struct packed {
    logic enable;
    logic bus_release_between_rw;
    logic overrun_sel;
    logic [3:0] unit_size;
    logic size_ok;
    logic transfer_done_flag;
  } dacc_cfg_t;

endpackage : dacc_pkg
`default_nettype wire

// ==== dacc_step.sv ====
// module: next transfer address for one channel side
`default_nettype none
module dacc_step
  import dacc_pkg::*;
(
  input wire logic [31:0] addr,
  input wire logic [1:0] mode,
  input wire logic [3:0] size_code,
  input wire logic second_part,
  output logic [31:0] next_addr,
  output logic size_ok,
  output logic divided
);

  logic [31:0] unit;
  logic narrow;

  always_comb begin
    unit = 32'h0000_0000;
    narrow = 1'b0;
    divided = 1'b0;
    size_ok = 1'b1;
    case (size_code)
      SZ_BYTE: begin
        unit = 32'h0000_0001;
        narrow = 1'b1;
      end
      SZ_WORD: begin
        unit = 32'h0000_0002;
        narrow = 1'b1;
      end
      SZ_LONG: begin
        unit = 32'h0000_0004;
        narrow = 1'b1;
      end
      SZ_8: unit = 32'h0000_0008;
      SZ_16: unit = 32'h0000_0010;
      SZ_32: unit = 32'h0000_0020;
      SZ_16_DIV: begin
        unit = 32'h0000_0008;
        divided = 1'b1;
      end
      SZ_32_DIV: begin
        unit = 32'h0000_0010;
        divided = 1'b1;
      end
      default: size_ok = 1'b0;
    endcase
  end

  always_comb begin
    next_addr = addr;
    case (mode)
      AM_INC: next_addr = addr + unit;
      AM_DEC: next_addr = narrow ? addr - unit : addr;
      AM_FIXED: begin
        if (divided) begin
          next_addr = second_part ? addr - unit : addr + unit;
        end
      end
      AM_HOLD: next_addr = addr;
      default: next_addr = addr;
    endcase
  end

endmodule : dacc_step
`default_nettype wire

// ==== dacc_eng.sv ====
// partner model: transfer engine that issues unit steps to the channel core
`default_nettype none
module dacc_eng
  import dacc_pkg::*;
(
  input wire logic hclk,
  output logic step_valid,
  output logic [2:0] step_chan,
  output logic step_second
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    step_valid = 1'b0;
    step_chan = 3'h7;
    step_second = 1'b0;
  end

  // ------------------------------------------------------------
  // one step pulse, then idle with inverted qualifiers
  // ------------------------------------------------------------
  task automatic issue(input logic [2:0] ch, input logic second);
    step_valid <= 1'b1;
    step_chan <= ch;
    step_second <= second;
    @(posedge hclk);
    step_valid <= 1'b0;
    step_chan <= ~ch;
    step_second <= ~second;
    @(posedge hclk);
  endtask : issue
endmodule : dacc_eng
`default_nettype wire

// ==== dacc_core_chk.sv ====
// checker: bus timing and register field properties of the channel core
`default_nettype none
module dacc_core_chk
  import dacc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic step_valid,
  input wire logic [2:0] step_chan,
  input wire logic step_second,
  input wire dacc_cfg_t chan_cfg [CHANNELS]
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ------------------------------------------------------------
  // sequences
  // ------------------------------------------------------------
  sequence s_rd;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence s_wr;
    hsel && hready && htrans[1] && hwrite;
  endsequence
  sequence s_ctrl0_wr;
    s_wr ##0 (haddr == 32'h0000_002C);
  endsequence

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_wr_nowait;
    s_wr |=> hreadyout;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write waited");
  property p_rd_wait;
    s_rd |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_low_cause;
    $fell(hreadyout) |-> $past(hsel && hready && htrans[1] && !hwrite);
  endproperty
  a_low_cause: assert property (p_low_cause) else $error("stray wait");
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("error response");
  property p_cnt_hi;
    s_rd ##0 (haddr[31:8] == 24'h0 && haddr[3:0] == 4'h8)
      |-> ##2 hrdata[31:24] == 8'h00;
  endproperty
  a_cnt_hi: assert property (p_cnt_hi) else $error("count top bits");
  property p_ctrl_rsvd;
    s_rd ##0 (haddr[31:8] == 24'h0 && haddr[3:0] == 4'hC)
      |-> ##2 (hrdata[31] == 1'b0 && hrdata[29:28] == 2'h0
      && hrdata[22] == 1'b0);
  endproperty
  a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("reserved set");
  property p_unmapped;
    s_rd ##0 (haddr[31:12] != 20'h0) |-> ##2 hrdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  property p_cfg_follow;
    s_ctrl0_wr |-> ##3 (chan_cfg[0].enable == $past(hwdata[0], 2)
      && chan_cfg[0].bus_release_between_rw == $past(hwdata[30], 2)
      && chan_cfg[0].unit_size == {$past(hwdata[21:20], 2),
      $past(hwdata[4:3], 2)});
  endproperty
  a_cfg_follow: assert property (p_cfg_follow) else $error("cfg lag");
  property p_overrun_lim;
    !(chan_cfg[2].overrun_sel || chan_cfg[3].overrun_sel
      || chan_cfg[4].overrun_sel || chan_cfg[5].overrun_sel);
  endproperty
  a_overrun_lim: assert property (p_overrun_lim) else $error("overrun");
endmodule : dacc_core_chk

bind dacc_core dacc_core_chk i_dacc_core_chk (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hsize(hsize),
  .hwdata(hwdata),
  .hready(hready),
  .hrdata(hrdata),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .step_valid(step_valid),
  .step_chan(step_chan),
  .step_second(step_second),
  .chan_cfg(chan_cfg)
);
`default_nettype wire

// ==== testbench.sv ====
// testbench: register access and step scenarios for the channel core
`default_nettype none
module testbench
  import dacc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic step_valid, step_second;
  logic [2:0] step_chan;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  dacc_cfg_t chan_cfg [CHANNELS];
  int n_mismatch = 0;
  int n_checks = 0;
  logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h2, 4'h7, 4'h3, 4'h4, 4'hB, 4'hC,
    4'h5};
  logic [31:0] incs [9] = '{32'h1, 32'h2, 32'h4, 32'h8, 32'h10, 32'h20,
    32'h10, 32'h20, 32'h0};

  dacc_core i_dacc_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .step_valid(step_valid),
    .step_chan(step_chan), .step_second(step_second), .chan_cfg(chan_cfg));
  dacc_eng i_dacc_eng (.hclk(hclk), .step_valid(step_valid),
    .step_chan(step_chan), .step_second(step_second));

  // ------------------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] ra(input logic [2:0] c, input logic [3:0] o);
    ra = {20'h0, CH_BASE[c]} + {28'h0, o};
  endfunction : ra
  function automatic logic [31:0] sa(input logic [2:0] c, input logic [3:0] o);
    sa = {20'h0, SHADOW_BASE + {5'h0, c, 4'h0}} + {28'h0, o};
  endfunction : sa
  function automatic logic [31:0] ctl(input logic [3:0] s);
    ctl = 32'h0000_5001 | {10'h0, s[3:2], 15'h0, s[1:0], 3'h0};
  endfunction : ctl
  task automatic ahb_wr(input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    @(posedge hclk iff hreadyout === 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk iff hreadyout === 1'b1);
  endtask : ahb_wr
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic chk(input logic [31:0] a, input logic [31:0] exp);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= 1'b0;
    @(posedge hclk iff hreadyout === 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    @(posedge hclk iff hreadyout === 1'b1);
    cmp(hrdata, exp);
  endtask : chk
  task automatic setup(input logic [2:0] c, input logic [31:0] cnt,
      input logic [31:0] cr);
    ahb_wr(ra(c, OFS_SRC), 32'h0000_1000);
    ahb_wr(ra(c, OFS_DST), 32'h0000_2000);
    ahb_wr(ra(c, OFS_CNT), cnt);
    ahb_wr(ra(c, OFS_CTRL), cr);
  endtask : setup
  task automatic stop_test;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    stop_test();
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int c = 0; c < 6; c++) begin
      for (int o = 0; o < 16; o += 4) begin
        chk(ra(c[2:0], o[3:0]), REG_RESET);
        if (c < 4 && o < 12) chk(sa(c[2:0], o[3:0]), REG_RESET);
      end
    end
    ahb_wr(ra(0, OFS_SRC), 32'h0000_1000);
    chk(sa(0, OFS_SRC), 32'h0000_1000);
    ahb_wr(sa(0, OFS_SRC), 32'h0000_1100);
    chk(ra(0, OFS_SRC), 32'h0000_1000);
    chk(sa(0, OFS_SRC), 32'h0000_1100);
    ahb_wr(ra(0, OFS_DST), 32'h0000_2000);
    chk(sa(0, OFS_DST), 32'h0000_2000);
    ahb_wr(ra(0, OFS_CNT), 32'hFFFF_FFFF);
    chk(ra(0, OFS_CNT), 32'h00FF_FFFF);
    chk(sa(0, OFS_CNT), 32'hFFFF_FFFF);
    for (int c = 0; c < 3; c += 2) begin
      ahb_wr(ra(c[2:0], OFS_CTRL), 32'hF1C8_0000);
      chk(ra(c[2:0], OFS_CTRL), 32'h4080_0000);
    end
    cmp({31'h0, chan_cfg[0].overrun_sel}, 32'h1);
    cmp({31'h0, chan_cfg[2].overrun_sel}, 32'h0);
    cmp({31'h0, chan_cfg[0].bus_release_between_rw}, 32'h1);
    setup(3'h0, 32'h3, 32'h0000_5011);
    i_dacc_eng.issue(3'h0, 1'b0);
    chk(ra(0, OFS_SRC), 32'h0000_1004);
    chk(ra(0, OFS_DST), 32'h0000_2004);
    chk(ra(0, OFS_CNT), 32'h2);
    i_dacc_eng.issue(3'h0, 1'b0);
    chk(ra(0, OFS_CTRL), 32'h0000_5011);
    i_dacc_eng.issue(3'h0, 1'b0);
    chk(ra(0, OFS_CNT), 32'h0);
    chk(ra(0, OFS_CTRL), 32'h0000_5013);
    cmp({31'h0, chan_cfg[0].transfer_done_flag}, 32'h1);
    i_dacc_eng.issue(3'h0, 1'b0);
    chk(ra(0, OFS_SRC), 32'h0000_100C);
    setup(3'h5, 32'h0, 32'h0000_5011);
    i_dacc_eng.issue(3'h5, 1'b0);
    chk(ra(5, OFS_CNT), 32'h00FF_FFFF);
    chk(ra(5, OFS_CTRL), 32'h0000_5011);
    for (int i = 0; i < 9; i++) begin
      setup(3'h1, 32'h5, ctl(codes[i]));
      i_dacc_eng.issue(3'h1, 1'b0);
      if (codes[i][3]) i_dacc_eng.issue(3'h1, 1'b1);
      chk(ra(1, OFS_SRC), 32'h0000_1000 + incs[i]);
      if (i < 8) chk(ra(1, OFS_CNT), 32'h4);
    end
    cmp({31'h0, chan_cfg[1].size_ok}, 32'h0);
    setup(3'h3, 32'h5, 32'h0000_E011);
    i_dacc_eng.issue(3'h3, 1'b0);
    chk(ra(3, OFS_SRC), 32'h0000_0FFC);
    chk(ra(3, OFS_DST), 32'h0000_2000);
    setup(3'h3, 32'h5, 32'h0020_0019);
    i_dacc_eng.issue(3'h3, 1'b0);
    chk(ra(3, OFS_SRC), 32'h0000_1008);
    i_dacc_eng.issue(3'h3, 1'b1);
    chk(ra(3, OFS_DST), 32'h0000_2000);
    chk(ra(3, OFS_CNT), 32'h4);
    for (int r = 1; r < 8; r++) begin
      if (r != 4) begin
        setup(3'h2, 32'h2, 32'h0000_5011 | (r << 25));
        ahb_wr(sa(2, OFS_SRC), 32'h0000_1000);
        ahb_wr(sa(2, OFS_CNT), (r > 4) ? 32'h0002_0002 : 32'h2);
        i_dacc_eng.issue(3'h2, 1'b0);
        chk(ra(2, OFS_SRC), 32'h0000_1004);
        i_dacc_eng.issue(3'h2, 1'b0);
        chk(ra(2, OFS_SRC), (r % 4 == 2) ? 32'h1008 : 32'h1000);
        chk(ra(2, OFS_DST), (r % 4 == 3) ? 32'h2008 : 32'h2000);
        chk(ra(2, OFS_CNT), (r > 4) ? 32'h0 : 32'h2);
        chk(sa(2, OFS_CNT), (r > 4) ? 32'h0002_0002 : 32'h2);
      end
    end
    setup(3'h4, 32'h1, 32'h0200_5011);
    i_dacc_eng.issue(3'h4, 1'b0);
    chk(ra(4, OFS_SRC), 32'h0000_1004);
    chk(ra(4, OFS_CTRL), 32'h0200_5013);
    ahb_wr(32'h1000_0020, 32'hFFFF_FFFF);
    ahb_wr(32'h0000_012C, 32'hFFFF_FFFF);
    chk(32'h1000_0020, 32'h0);
    chk(32'h0000_012C, 32'h0);
    chk(ra(0, OFS_SRC), 32'h0000_100C);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
